// *** design/rafl_pkg.sv ***
// constants shared by the reading average filter files
package rafl_pkg;
    // ****************************************************************
    // register map (byte addresses, one 32-bit word each)
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CONFIG = 8'h04;
    localparam logic [7:0] ADR_INTEG = 8'h08;
    localparam logic [7:0] ADR_DIGITS = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADR_AVG = 8'h1C;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_EN = 0;
    localparam int CTRL_RESP_LO = 1;
    localparam int CTRL_TYPE_LO = 3;
    localparam int CTRL_PRESET = 5;
    localparam int CTRL_IFC_RST = 6;
    localparam int CFG_FUNC_LO = 0;
    localparam int CFG_RANGE_LO = 2;
    localparam int CFG_CHAN = 5;
    localparam int CFG_TC = 6;
    localparam int ST_SETTLED = 0;
    localparam int ST_ANALOG = 1;
    localparam int ST_COUNT_LO = 8;
    localparam int IRQ_READING = 0;
    localparam int IRQ_CNT_RESET = 1;
    localparam int IRQ_SETTLED = 2;
    localparam int IRQ_W = 3;
    // ****************************************************************
    // encodings and reset values
    // ****************************************************************
    localparam logic [1:0] RESP_FAST = 2'h0;
    localparam logic [1:0] RESP_MEDIUM = 2'h1;
    localparam logic [1:0] RESP_SLOW = 2'h2;
    localparam logic [1:0] TYPE_DIGITAL = 2'h0;
    localparam logic [1:0] TYPE_ANALOG = 2'h1;
    localparam logic [1:0] TYPE_COMBINED = 2'h2; // combined_filter_select
    localparam logic [1:0] FUNC_DCV = 2'h0;
    localparam logic [1:0] FUNC_RES = 2'h1;
    localparam logic [1:0] FUNC_FRES = 2'h2;
    localparam logic [1:0] FUNC_TEMP = 2'h3;
    localparam logic [2:0] RANGE_1MV = 3'h0;
    localparam logic [2:0] RANGE_100MV = 3'h2;
    // integration_line_cycles codes: 0.02 0.2 1 2 10 20 100 200
    localparam logic [2:0] ILC_0P02 = 3'h0;
    localparam logic [2:0] ILC_0P2 = 3'h1;
    localparam logic [2:0] ILC_10 = 3'h4;
    localparam logic [2:0] ILC_20 = 3'h5;
    localparam logic [2:0] ILC_RESET = ILC_10;
    localparam logic [2:0] DIG_MIN = 3'h4;
    localparam logic [2:0] DIG_RESET = 3'h6;
    localparam logic [2:0] DIG_MAX = 3'h7;
    // ****************************************************************
    // window lengths, deviation bands, timing
    // ****************************************************************
    localparam logic [6:0] LEN_FAST = 7'h0A;
    localparam logic [6:0] LEN_MEDIUM = 7'h32;
    localparam logic [6:0] LEN_SLOW = 7'h64;
    localparam int PPM_FAST_1MV = 400;
    localparam int PPM_MED_1MV = 700;
    localparam int PPM_SLOW_1MV = 2000;
    localparam int PPM_FAST = 100;
    localparam int PPM_MED = 300;
    localparam int PPM_SLOW = 1000;
    localparam longint PPM_DEN = 1000000;
    localparam int CLK_HZ = 25000000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int DW = 24;
    localparam int CW = 7;
    localparam int DEPTH = 100;
endpackage : rafl_pkg

// *** design/rafl_avg_if.sv ***
// carrier between the control logic and the boxcar core
`timescale 1ns/1ns
interface rafl_avg_if;
    logic push;
    logic restart;
    logic clear;
    logic [rafl_pkg::CW-1:0] len;
    logic signed [rafl_pkg::DW-1:0] sample;
    logic signed [rafl_pkg::DW-1:0] avg;
    logic [rafl_pkg::CW-1:0] count;
    logic done;
    modport ctl (output push, restart, clear, len, sample,
                 input avg, count, done);
    modport core (input push, restart, clear, len, sample,
                  output avg, count, done);
endinterface : rafl_avg_if

// *** design/rafl_boxcar.sv ***
// equal-weight moving average core with its own sample ring
`timescale 1ns/1ns
module rafl_boxcar #(
    parameter int DEPTH = rafl_pkg::DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst,
    rafl_avg_if.core bus
);
    localparam int DW = rafl_pkg::DW;
    localparam int CW = rafl_pkg::CW;
    logic signed [DW-1:0] mem [0:DEPTH-1];
    logic signed [31:0] sum;
    logic [CW-1:0] wptr;
    logic start;
    logic [CW-1:0] waddr;
    logic [CW-1:0] next_wptr;
    logic signed [31:0] next_sum;
    logic [CW-1:0] next_count;
    logic signed [31:0] den;
    logic signed [31:0] quot;
    logic signed [31:0] ext;
    logic signed [31:0] oldest;

    // a reset of the count starts a fresh window with this sample
    assign start = bus.restart | bus.clear | (bus.count == '0);
    assign waddr = start ? '0 : wptr;
    assign ext = 32'(bus.sample);
    assign oldest = 32'(mem[wptr]);

    // running sum: grow until full, then drop the oldest sample
    always_comb begin
        next_sum = sum;
        next_count = bus.count;
        if (start) begin
            next_sum = ext;
            next_count = 7'h01;
        end else if (bus.count < bus.len) begin
            next_sum = sum + ext;
            next_count = bus.count + 7'h01;
        end else begin
            next_sum = sum + ext - oldest;
        end
        next_wptr = (waddr + 7'h01 == bus.len) ? '0 : waddr + 7'h01;
        den = {25'h000_0000, next_count};
        quot = next_sum / den;
    end

    // sample ring, written only on a triggered reading
    always_ff @(posedge i_clk) begin
        if (bus.push) begin
            mem[waddr] <= bus.sample;
        end
    end

    // window state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sum <= 32'h0000_0000;
            bus.count <= '0;
            wptr <= '0;
        end else if (bus.push) begin
            sum <= next_sum;
            bus.count <= next_count;
            wptr <= next_wptr;
        end else if (bus.clear) begin
            sum <= 32'h0000_0000;
            bus.count <= '0;
            wptr <= '0;
        end
    end

    // averaged result, one cycle after the push
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus.avg <= '0;
            bus.done <= 1'b0;
        end else begin
            bus.done <= bus.push;
            if (bus.push) begin
                bus.avg <= quot[DW-1:0];
            end
        end
    end
endmodule : rafl_boxcar

// *** design/rafl_top.sv ***
// reading average filter: control, status and wishbone registers
// Function
// - output is equal-weight boxcar average of window
// - window lengths 100 slow, 50 medium, 10 fast
// - mean of readings so far, indicator flashes
// - filter advances only on triggered readings
// - config change resets count, restarts flashing; a tc or filter type change does not
// - 1 mV deviation bands 400/700/2000 ppm
// - other ranges bands 100/300/1000 ppm
// - settled status bit reported with each reading
// - remote reset or preset disables digital filter
// - filter type digital, analog or both, restricted; analog type still runs the digital average
// - eight integration choices, 10 after reset
// - integration time remembered per measurement function
// - digit cap from integration time and filter
`timescale 1ns/1ns
module rafl_top #(
    parameter int FS_COUNTS = 1000000,
    parameter int FLASH_CYCLES = rafl_pkg::FLASH_CYC
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rdg_valid,
    input wire logic signed [rafl_pkg::DW-1:0] i_rdg_data,
    output logic o_out_valid,
    output logic signed [rafl_pkg::DW-1:0] o_out_data,
    output logic o_out_settled,
    output logic o_filt_ind,
    output logic o_analog_en,
    output logic [2:0] o_integ_code,
    output logic [2:0] o_digits,
    output logic o_irq
);
    // ****************************************************************
    // deviation thresholds in reading counts
    // ****************************************************************
    localparam longint FS = FS_COUNTS;
    localparam logic [31:0] THR_F1 =
        32'(FS * rafl_pkg::PPM_FAST_1MV / rafl_pkg::PPM_DEN);
    localparam logic [31:0] THR_M1 =
        32'(FS * rafl_pkg::PPM_MED_1MV / rafl_pkg::PPM_DEN);
    localparam logic [31:0] THR_S1 =
        32'(FS * rafl_pkg::PPM_SLOW_1MV / rafl_pkg::PPM_DEN);
    localparam logic [31:0] THR_F =
        32'(FS * rafl_pkg::PPM_FAST / rafl_pkg::PPM_DEN);
    localparam logic [31:0] THR_M =
        32'(FS * rafl_pkg::PPM_MED / rafl_pkg::PPM_DEN);
    localparam logic [31:0] THR_S =
        32'(FS * rafl_pkg::PPM_SLOW / rafl_pkg::PPM_DEN);
    localparam logic [23:0] FLASH_LAST = 24'(FLASH_CYCLES - 1);

    // ****************************************************************
    // declarations
    // ****************************************************************
    rafl_avg_if avg_bus ();
    logic filt_on;
    logic [1:0] resp;
    logic [1:0] ftype;
    logic [1:0] func;
    logic [2:0] range_sel;
    logic chan;
    logic tc;
    logic [2:0] integ_tbl [0:3];
    logic [2:0] dig_req;
    logic [rafl_pkg::IRQ_W-1:0] irq_stat;
    logic [rafl_pkg::IRQ_W-1:0] irq_mask;
    logic [23:0] flash_cnt;
    logic blink;
    logic req;
    logic wr;
    logic [7:0] wd;
    logic cfg_chg;
    logic integ_chg;
    logic ctrl_chg;
    logic clear_req;
    logic dev_reset;
    logic analog_ok;
    logic settled;
    logic [2:0] dig_cap;
    logic [2:0] dig_shown;
    logic [31:0] thr;
    logic signed [31:0] diff;
    logic [31:0] mag;
    logic [rafl_pkg::IRQ_W-1:0] irq_set;
    logic [31:0] rd_val;
    logic [6:0] win_len;

    // ****************************************************************
    // register bus decode
    // ****************************************************************
    assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
    assign wd = i_wb_dat[7:0];

    // change detection on configuration writes
    always_comb begin
        cfg_chg = 1'b0;
        integ_chg = 1'b0;
        ctrl_chg = 1'b0;
        if (wr && i_wb_adr == rafl_pkg::ADR_CONFIG) begin
            cfg_chg = (wd[1:0] != func) | (wd[4:2] != range_sel)
                | (wd[rafl_pkg::CFG_CHAN] != chan);
        end
        if (wr && i_wb_adr == rafl_pkg::ADR_INTEG) begin
            integ_chg = wd[2:0] != integ_tbl[func];
        end
        if (wr && i_wb_adr == rafl_pkg::ADR_CTRL) begin
            ctrl_chg = (wd[2:1] != resp) | (wd[rafl_pkg::CTRL_EN] & ~filt_on);
        end
    end
    assign clear_req = cfg_chg | integ_chg | ctrl_chg;

    // ****************************************************************
    // control registers
    // ****************************************************************
    // filter enable, response and type; reset and preset switch it off
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            filt_on <= 1'b0;
            resp <= rafl_pkg::RESP_FAST;
            ftype <= rafl_pkg::TYPE_DIGITAL;
        end else if (wr && i_wb_adr == rafl_pkg::ADR_CTRL) begin
            resp <= (wd[2:1] == 2'h3) ? rafl_pkg::RESP_SLOW : wd[2:1];
            ftype <= (wd[4:3] == 2'h3) ? rafl_pkg::TYPE_COMBINED
                : wd[4:3];
            if (wd[rafl_pkg::CTRL_PRESET] || wd[rafl_pkg::CTRL_IFC_RST]) begin
                filt_on <= 1'b0;
            end else begin
                filt_on <= wd[rafl_pkg::CTRL_EN];
            end
        end
    end

    // measurement configuration
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            func <= rafl_pkg::FUNC_DCV;
            range_sel <= rafl_pkg::RANGE_1MV;
            chan <= 1'b0;
            tc <= 1'b0;
        end else if (wr && i_wb_adr == rafl_pkg::ADR_CONFIG) begin
            func <= wd[1:0];
            range_sel <= wd[4:2];
            chan <= wd[rafl_pkg::CFG_CHAN];
            tc <= wd[rafl_pkg::CFG_TC];
        end
    end

    // per-function integration time table
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < 4; i++) begin
                integ_tbl[i] <= rafl_pkg::ILC_RESET;
            end
        end else if (wr && i_wb_adr == rafl_pkg::ADR_CTRL
                     && wd[rafl_pkg::CTRL_IFC_RST]) begin
            for (int i = 0; i < 4; i++) begin
                integ_tbl[i] <= rafl_pkg::ILC_RESET;
            end
        end else if (wr && i_wb_adr == rafl_pkg::ADR_INTEG) begin
            integ_tbl[func] <= wd[2:0];
        end
    end

    // requested digits, restored on interface reset or preset
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            dig_req <= rafl_pkg::DIG_RESET;
        end else if (wr && i_wb_adr == rafl_pkg::ADR_CTRL
                     && (wd[rafl_pkg::CTRL_IFC_RST]
                         || wd[rafl_pkg::CTRL_PRESET])) begin
            dig_req <= rafl_pkg::DIG_RESET;
        end else if (wr && i_wb_adr == rafl_pkg::ADR_DIGITS) begin
            dig_req <= (wd[2:0] < rafl_pkg::DIG_MIN) ? rafl_pkg::DIG_MIN
                : wd[2:0];
        end
    end

    // ****************************************************************
    // derived settings
    // ****************************************************************
    always_comb begin
        case (resp)
            rafl_pkg::RESP_MEDIUM: win_len = rafl_pkg::LEN_MEDIUM;
            rafl_pkg::RESP_SLOW: win_len = rafl_pkg::LEN_SLOW;
            default: win_len = rafl_pkg::LEN_FAST;
        endcase
        if (range_sel == rafl_pkg::RANGE_1MV) begin
            case (resp)
                rafl_pkg::RESP_MEDIUM: thr = THR_M1;
                rafl_pkg::RESP_SLOW: thr = THR_S1;
                default: thr = THR_F1;
            endcase
        end else begin
            case (resp)
                rafl_pkg::RESP_MEDIUM: thr = THR_M;
                rafl_pkg::RESP_SLOW: thr = THR_S;
                default: thr = THR_F;
            endcase
        end
        // digit cap: filter off / on
        case (integ_tbl[func])
            rafl_pkg::ILC_0P02: dig_cap = filt_on ? 3'h5 : 3'h4;
            rafl_pkg::ILC_0P2: dig_cap = filt_on ? 3'h6 : 3'h5;
            3'h2, 3'h3, rafl_pkg::ILC_10:
                dig_cap = filt_on ? 3'h7 : 3'h6;
            default: dig_cap = rafl_pkg::DIG_MAX;
        endcase
        dig_shown = (dig_req > dig_cap) ? dig_cap : dig_req;
        // analog path only for thermocouple or low voltage ranges
        analog_ok = (func == rafl_pkg::FUNC_TEMP && tc)
            || (func == rafl_pkg::FUNC_DCV
                && range_sel <= rafl_pkg::RANGE_100MV);
    end

    // ****************************************************************
    // averaging core and deviation check
    // ****************************************************************
    assign diff = 32'(i_rdg_data) - 32'(avg_bus.avg);
    assign mag = diff[31] ? 32'(-diff) : diff;
    assign dev_reset = (avg_bus.count != '0) && (mag > thr);
    assign settled = avg_bus.count == win_len;
    assign avg_bus.push = i_rdg_valid & filt_on;
    assign avg_bus.restart = dev_reset;
    assign avg_bus.clear = clear_req;
    assign avg_bus.len = win_len;
    assign avg_bus.sample = i_rdg_data;

    rafl_boxcar #(
        .DEPTH(rafl_pkg::DEPTH)
    ) u_boxcar (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .bus(avg_bus)
    );

    // ****************************************************************
    // reading output path
    // ****************************************************************
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
            o_out_settled <= 1'b0;
        end else if (avg_bus.done) begin
            o_out_valid <= 1'b1;
            o_out_data <= avg_bus.avg;
            o_out_settled <= settled;
        end else if (i_rdg_valid && !filt_on) begin
            o_out_valid <= 1'b1;
            o_out_data <= i_rdg_data;
            o_out_settled <= 1'b1;
        end else begin
            o_out_valid <= 1'b0;
        end
    end

    // flash timebase for the filter indicator
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            flash_cnt <= 24'h00_0000;
            blink <= 1'b0;
        end else if (flash_cnt >= FLASH_LAST) begin
            flash_cnt <= 24'h00_0000;
            blink <= ~blink;
        end else begin
            flash_cnt <= flash_cnt + 24'h00_0001;
        end
    end

    // status pins: indicator steady only once the window is full
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_filt_ind <= 1'b0;
            o_analog_en <= 1'b0;
            o_integ_code <= rafl_pkg::ILC_RESET;
            o_digits <= rafl_pkg::DIG_RESET;
        end else begin
            o_filt_ind <= filt_on & (settled | blink);
            o_analog_en <= filt_on & (ftype != rafl_pkg::TYPE_DIGITAL)
                & analog_ok;
            o_integ_code <= integ_tbl[func];
            o_digits <= dig_shown;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign irq_set[rafl_pkg::IRQ_READING] = avg_bus.done
        | (i_rdg_valid & ~filt_on);
    assign irq_set[rafl_pkg::IRQ_CNT_RESET] = filt_on
        & ((avg_bus.push & dev_reset) | clear_req);
    assign irq_set[rafl_pkg::IRQ_SETTLED] = avg_bus.done & settled;

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_stat <= '0;
        end else if (wr && i_wb_adr == rafl_pkg::ADR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wd[rafl_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    // mask register and level interrupt output
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_mask <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr && i_wb_adr == rafl_pkg::ADR_IRQ_MASK) begin
                irq_mask <= wd[rafl_pkg::IRQ_W-1:0];
            end
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // ****************************************************************
    // read mux and acknowledge
    // ****************************************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        case (i_wb_adr)
            rafl_pkg::ADR_CTRL:
                rd_val[4:0] = {ftype, resp, filt_on};
            rafl_pkg::ADR_CONFIG:
                rd_val[6:0] = {tc, chan, range_sel, func};
            rafl_pkg::ADR_INTEG: rd_val[2:0] = integ_tbl[func];
            rafl_pkg::ADR_DIGITS: rd_val[6:0] = {dig_cap, 1'b0, dig_shown};
            rafl_pkg::ADR_STATUS: begin
                rd_val[rafl_pkg::ST_SETTLED] = settled | ~filt_on;
                rd_val[rafl_pkg::ST_ANALOG] = o_analog_en;
                rd_val[14:8] = avg_bus.count;
            end
            rafl_pkg::ADR_IRQ_STAT: rd_val[2:0] = irq_stat;
            rafl_pkg::ADR_IRQ_MASK: rd_val[2:0] = irq_mask;
            rafl_pkg::ADR_AVG: rd_val = 32'(avg_bus.avg);
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // one wait state, ack drops the cycle after it is given
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= req;
            if (req && !i_wb_we) begin
                o_wb_dat <= rd_val;
            end
        end
    end
endmodule : rafl_top

// *** dv/rafl_adc_model.sv ***
// converter model that hands the filter one reading per trigger
`timescale 1ns/1ns
module rafl_adc_model (
    input wire logic i_clk,
    input wire logic i_trig,
    input wire logic signed [rafl_pkg::DW-1:0] i_val,
    output logic o_valid,
    output logic signed [rafl_pkg::DW-1:0] o_data
);
    // ********
    // reading launch
    // ********
    initial o_data = '0;
    // data is scrambled between readings so nothing leans on a held value
    always @(posedge i_clk) begin
        o_valid <= i_trig;
        o_data <= i_trig ? i_val : ~o_data;
    end
endmodule : rafl_adc_model

// *** dv/rafl_top_chk.sv ***
// assertions on the reading average filter top ports
`timescale 1ns/1ns
module rafl_top_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_rdg_valid,
    input wire logic o_out_valid,
    input wire logic signed [rafl_pkg::DW-1:0] o_out_data,
    input wire logic o_out_settled,
    input wire logic [2:0] o_digits
);
    // ********
    // port timing and digit range checks
    // ********
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property
        (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered next cycle");
    a_ack_unasked: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("ack without request");
    a_rdg_answer: assert property (i_rdg_valid |-> ##[1:2] o_out_valid)
        else $error("reading not answered");
    a_out_cause: assert property
        (o_out_valid |-> $past(i_rdg_valid) || $past(i_rdg_valid, 2))
        else $error("output without reading");
    a_data_hold: assert property (!o_out_valid |-> $stable(o_out_data))
        else $error("output data moved between readings");
    a_settled_hold: assert property (!o_out_valid |-> $stable(o_out_settled))
        else $error("settled bit moved between readings");
    a_digits_floor: assert property (o_digits >= 3'h4 && o_digits <= 3'h7)
        else $error("digit count out of span");
endmodule : rafl_top_chk

bind rafl_top rafl_top_chk i_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
    .i_rdg_valid(i_rdg_valid), .o_out_valid(o_out_valid),
    .o_out_data(o_out_data), .o_out_settled(o_out_settled),
    .o_digits(o_digits));

// *** dv/rafl_top_tb.sv ***
// self-checking bench for the reading average filter
`timescale 1ns/1ns
module rafl_top_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic trig = 1'b0, rv, ov, os, ind, irq, ack, ae;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, wd, rdat;
    logic signed [rafl_pkg::DW-1:0] val = '0, rdg, od;
    logic [2:0] ic, dg;
    int failures = 0, n_compared = 0, q[$], avg, sd = 11;
    int thr[6] = '{400, 700, 2000, 100, 300, 1000};
    int len[3] = '{10, 50, 100};
    // ********
    // clock, converter and filter
    // ********
    always #20 clk = ~clk;
    rafl_adc_model i_adc (.i_clk(clk), .i_trig(trig), .i_val(val),
        .o_valid(rv), .o_data(rdg));
    rafl_top #(.FLASH_CYCLES(4)) i_dut (.I_SYS_CLK(clk), .I_RST(rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(wd), .o_wb_ack(ack),
        .i_rdg_valid(rv), .i_rdg_data(rdg), .o_out_valid(ov),
        .o_out_data(od), .o_out_settled(os), .o_filt_ind(ind),
        .o_analog_en(ae), .o_integ_code(ic), .o_digits(dg), .o_irq(irq));
    function automatic int rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd & 32'h7FFF_FFFF;
    endfunction : rnd
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic idle(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : idle
    // one classic cycle, waits for ack under a bound
    task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        rdat = wd;
        {cyc, stb} <= 2'h0;
        if (n >= 20) failures++;
    endtask : wb
    // a negative band means the filter is off and the reading passes raw
    task automatic take(int v, int t, int l);
        int n = 0, s = 0;
        logic b;
        @(posedge clk);
        {trig, val} <= {1'b1, 24'(v)};
        @(posedge clk);
        trig <= 1'b0;
        do idle(1); while (ov !== 1'b1 && ++n < 8);
        if (n >= 8) failures++;
        if (t >= 0 && q.size() > 0 && (v - avg > t || avg - v > t))
            q.delete();
        if (t >= 0) q.push_back(v);
        if (q.size() > l) void'(q.pop_front());
        foreach (q[i]) s += q[i];
        avg = t < 0 ? v : s / q.size();
        chk("data", 32'(od), 32'(avg));
        chk("settled", os, t < 0 || q.size() == l);
        if (t >= 0 && q.size() == l) chk("ind", ind, 1);
        // unsettled: the indicator toggles once every four cycles
        if (t >= 0 && q.size() < l) begin
            b = ind;
            idle(4);
            chk("blink", ind, !b);
        end
    endtask : take
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // ********
    // scenarios
    // ********
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        chk("integ", ic, 4);
        chk("digits", dg, 6);
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 3; m++) begin
                wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'(r * 4));
                wb(rafl_pkg::ADR_CTRL, 1'b1, 32'(1 + m * 2));
                q.delete();
                for (int k = 0; k < len[m] + 2; k++)
                    take(5000 + rnd() % (thr[r*3+m] / 2), thr[r*3+m], len[m]);
                take(5000 + thr[r*3+m] * 3, thr[r*3+m], len[m]);
                $display("window %0d range %0d done", len[m], r);
            end
        end
        wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'h0000_0001);
        wb(rafl_pkg::ADR_INTEG, 1'b1, 32'h0000_0007);
        wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'h0000_0000);
        idle(2);
        chk("integ", ic, 4);
        wb(rafl_pkg::ADR_INTEG, 1'b1, 32'h0000_0000);
        idle(2);
        chk("digits", dg, 5);
        wb(rafl_pkg::ADR_CTRL, 1'b1, 32'h0000_0020);
        idle(2);
        chk("digits", dg, 4);
        take(1234, -1, 0);
        wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'h0000_0001);
        idle(2);
        chk("integ", ic, 7);
        $display("integration and preset done");
        wb(rafl_pkg::ADR_CTRL, 1'b1, 32'h0000_0009);
        idle(2);
        chk("analog", ae, 0);
        wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'h0000_0000);
        idle(2);
        chk("analog", ae, 1);
        wb(rafl_pkg::ADR_CONFIG, 1'b1, 32'h0000_000C);
        idle(2);
        chk("analog", ae, 0);
        wb(rafl_pkg::ADR_CTRL, 1'b1, 32'h0000_0040);
        idle(2);
        chk("integ", ic, 4);
        chk("ind", ind, 0);
        chk("digits", dg, 6);
        wb(rafl_pkg::ADR_IRQ_MASK, 1'b1, 32'h0000_0001);
        idle(2);
        chk("irq", irq, 1);
        wb(rafl_pkg::ADR_IRQ_STAT, 1'b1, 32'h0000_0007);
        idle(2);
        chk("irq", irq, 0);
        wb(8'hFC, 1'b0, 32'h0000_0000);
        chk("unmapped", rdat, 0);
        $display("interrupt and bus done");
        print_verdict();
    end
    // watchdog well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule : rafl_top_tb
